//--- design/tape_option_consts.vh
// constants for the tape coupler option control block
//
// Operation
// - address width 22 bits when switch on
// - remote switch: density from mode bit 0
// - override off, status true: expect check characters
// - override on: ignore status, no check characters
// - extended gap only while streaming is selected
// - normal gap 0.6 inch, 2.5 ms window
// - extended gap 1.2 inch, 8.5 ms window
// - inhibit switch on blocks on-the-fly commands
// - strobe switch picks trailing or leading edge
`ifndef TAPE_OPTION_CONSTS_VH
`define TAPE_OPTION_CONSTS_VH

// apb register byte offsets
`define OPT_REG_SWITCHES 12'h000
`define OPT_REG_CHAR_MODE 12'h004
`define OPT_REG_STATUS 12'h008
`define OPT_REG_WINDOW 12'h00c

// latched switch field positions
`define SW_ADDR_WIDTH 0
`define SW_REMOTE_DENSITY 1
`define SW_STREAMING_MODE 2
`define SW_DENSITY_OVERRIDE 3
`define SW_EXTENDED_GAP 4
`define SW_FLY_INHIBIT 5
`define SW_STROBE_EDGE 6
`define SW_COUNT 7

// status field positions
`define ST_HIGH_DENSITY 0
`define ST_EXPECT_CHECK 1
`define ST_EXTENDED_GAP 2
`define ST_FLY_ENABLE 3
`define ST_WINDOW_RUN 4
`define ST_WINDOW_MISSED 5
`define ST_ADDR_22 6

// reset values
`define CHAR_MODE_RESET 8'h00
`define CHAR_DENSITY_BIT 0

// address widths
`define ADDR_BITS_WIDE 22
`define ADDR_BITS_NARROW 18

// gap lengths in tenths of an inch
`define GAP_NORMAL_TENTHS 4'h6
`define GAP_EXTENDED_TENTHS 4'hc

// command windows in microseconds, clock in mhz
`define WINDOW_NORMAL_US 2500
`define WINDOW_EXTENDED_US 8500
`define CLK_MHZ 25
`define WINDOW_WIDTH 18

`endif

//--- design/stream_window_timer.v
// countdown timer for the streaming command window
`timescale 1ns/1ps
module stream_window_timer #(
  parameter WIDTH = 18
) (
  input wire clk,
  input wire rst,
  input wire start,
  input wire stop,
  input wire [WIDTH-1:0] limit,
  output reg running,
  output reg expired,
  output reg [WIDTH-1:0] remaining
);

  // start loads the limit, stop wins over a pending expiry
  always @(posedge clk)
  begin
    if (rst)
    begin
      running <= 1'b0;
      expired <= 1'b0;
      remaining <= {WIDTH{1'b0}};
    end
    else
    begin
      expired <= 1'b0;
      if (stop)
      begin
        running <= 1'b0;
        remaining <= {WIDTH{1'b0}};
      end
      else if (start)
      begin
        running <= 1'b1;
        remaining <= limit;
      end
      else if (running)
      begin
        if (remaining <= {{(WIDTH-1){1'b0}}, 1'b1})
        begin
          running <= 1'b0;
          expired <= 1'b1;
          remaining <= {WIDTH{1'b0}};
        end
        else
          remaining <= remaining - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

//--- design/tape_option_control.v
// option switch handling for the tape coupler with apb register access
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "tape_option_consts.vh"
module tape_option_control #(
  parameter NORMAL_WINDOW_CYCLES = `WINDOW_NORMAL_US * `CLK_MHZ,
  parameter EXTENDED_WINDOW_CYCLES = `WINDOW_EXTENDED_US * `CLK_MHZ,
  parameter WIN_W = `WINDOW_WIDTH
) (
  input wire clk,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // option switches, on = 1
  input wire address_width_switch,
  input wire remote_density_switch,
  input wire streaming_mode_switch,
  input wire density_status_override_switch,
  input wire extended_gap_switch,
  input wire fly_command_inhibit_switch,
  input wire strobe_edge_switch,
  // local density selection and transport status
  input wire local_density_select,
  input wire density_status_line,
  // dma address path
  input wire [21:0] dma_addr,
  output reg [21:0] bus_addr_r,
  // streaming command window
  input wire record_done,
  input wire rw_command,
  output reg window_missed_r,
  // on-the-fly commands
  input wire fly_command_req,
  output reg fly_command_issue_r,
  // write data path
  input wire write_data_strobe,
  input wire [7:0] next_write_char,
  output reg [7:0] write_data_r,
  output reg write_char_taken_r,
  // option results
  output reg high_density_r,
  output reg expect_check_chars_r,
  output reg [3:0] gap_length_r
);

  reg [`SW_COUNT-1:0] switches_r;
  reg [7:0] char_mode_r;
  reg strobe_prev_r;
  reg missed_flag_r;
  wire streaming;
  wire extended_gap;
  wire [WIN_W-1:0] window_limit;
  wire window_running;
  wire window_expired;
  wire [WIN_W-1:0] window_remaining;
  wire apb_write;
  wire apb_setup;
  wire sw_clear_missed;
  wire strobe_edge_seen;

  // switches captured only while reset is held
  // moving a switch while running has no effect until the next reset
  always @(posedge clk)
  begin
    if (rst)
    begin
      switches_r[`SW_ADDR_WIDTH] <= address_width_switch;
      switches_r[`SW_REMOTE_DENSITY] <= remote_density_switch;
      switches_r[`SW_STREAMING_MODE] <= streaming_mode_switch;
      switches_r[`SW_DENSITY_OVERRIDE] <= density_status_override_switch;
      switches_r[`SW_EXTENDED_GAP] <= extended_gap_switch;
      switches_r[`SW_FLY_INHIBIT] <= fly_command_inhibit_switch;
      switches_r[`SW_STROBE_EDGE] <= strobe_edge_switch;
    end
  end

  // streaming is selected with the switch off; extended gap counts only then
  assign streaming = ~switches_r[`SW_STREAMING_MODE];
  assign extended_gap = streaming & switches_r[`SW_EXTENDED_GAP];
  assign window_limit = extended_gap ? EXTENDED_WINDOW_CYCLES[WIN_W-1:0]
                                     : NORMAL_WINDOW_CYCLES[WIN_W-1:0];

  // apb decode
  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pready & pwrite;
  assign sw_clear_missed = apb_write & (paddr == `OPT_REG_STATUS) & pwdata[`ST_WINDOW_MISSED];

  // window opens after each streamed record, closes on the next command
  stream_window_timer #(
    .WIDTH(WIN_W)
  ) u_window (
    .clk(clk),
    .rst(rst),
    .start(record_done & streaming),
    .stop(rw_command),
    .limit(window_limit),
    .running(window_running),
    .expired(window_expired),
    .remaining(window_remaining)
  );

  // option decisions, all from latched switches
  // narrow mode keeps the upper four address bits at zero
  always @(posedge clk)
  begin
    if (rst)
    begin
      bus_addr_r <= 22'h00_0000;
      high_density_r <= 1'b0;
      expect_check_chars_r <= 1'b0;
      gap_length_r <= `GAP_NORMAL_TENTHS;
      fly_command_issue_r <= 1'b0;
    end
    else
    begin
      if (switches_r[`SW_ADDR_WIDTH])
        bus_addr_r <= dma_addr;
      else
        bus_addr_r <= {4'h0, dma_addr[`ADDR_BITS_NARROW-1:0]};
      if (switches_r[`SW_REMOTE_DENSITY])
        high_density_r <= char_mode_r[`CHAR_DENSITY_BIT];
      else
        high_density_r <= local_density_select;
      // status true means nrzi unless override forces pe or gcr
      expect_check_chars_r <= ~switches_r[`SW_DENSITY_OVERRIDE] & density_status_line;
      gap_length_r <= extended_gap ? `GAP_EXTENDED_TENTHS : `GAP_NORMAL_TENTHS;
      fly_command_issue_r <= fly_command_req & ~switches_r[`SW_FLY_INHIBIT];
    end
  end

  // missed window: pulse to the transport side, sticky flag for software
  always @(posedge clk)
  begin
    if (rst)
    begin
      window_missed_r <= 1'b0;
      missed_flag_r <= 1'b0;
    end
    else
    begin
      window_missed_r <= window_expired;
      if (window_expired)
        missed_flag_r <= 1'b1; // set wins over clear
      else if (sw_clear_missed)
        missed_flag_r <= 1'b0;
    end
  end

  // strobe edge chosen by switch: on = leading (rise), off = trailing (fall)
  // previous level resets low, the idle strobe level, so no false edge
  assign strobe_edge_seen = switches_r[`SW_STROBE_EDGE] ? (write_data_strobe & ~strobe_prev_r)
                                                        : (~write_data_strobe & strobe_prev_r);

  // next character presented after the selected strobe edge
  always @(posedge clk)
  begin
    if (rst)
    begin
      strobe_prev_r <= 1'b0;
      write_data_r <= 8'h00;
      write_char_taken_r <= 1'b0;
    end
    else
    begin
      strobe_prev_r <= write_data_strobe;
      write_char_taken_r <= strobe_edge_seen;
      if (strobe_edge_seen)
        write_data_r <= next_write_char;
    end
  end

  // characteristic mode byte written by software
  always @(posedge clk)
  begin
    if (rst)
      char_mode_r <= `CHAR_MODE_RESET;
    else if (apb_write & (paddr == `OPT_REG_CHAR_MODE))
      char_mode_r <= pwdata[7:0];
  end

  // apb answer: ready one cycle after setup, read data loaded at setup
  // unmapped offsets answer with an error flag and zero data
  always @(posedge clk)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= apb_setup;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (apb_setup)
      begin
        case (paddr)
          `OPT_REG_SWITCHES:
            prdata <= {{(32-`SW_COUNT){1'b0}}, switches_r};
          `OPT_REG_CHAR_MODE:
            prdata <= {24'h00_0000, char_mode_r};
          `OPT_REG_STATUS:
            prdata <= {25'h000_0000, switches_r[`SW_ADDR_WIDTH], missed_flag_r, window_running,
                       ~switches_r[`SW_FLY_INHIBIT], extended_gap, expect_check_chars_r, high_density_r};
          `OPT_REG_WINDOW:
            prdata <= {{(32-WIN_W){1'b0}}, window_remaining};
          default:
            pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule

//--- bench/transport_model.sv
// tape transport model: density status line and write data strobe
`timescale 1ns/1ps
module transport_model (
  input wire clk,
  input wire nrzi_mode,
  input wire run,
  output reg density_status_line = 1'b0,
  output reg write_data_strobe = 1'b0
);
  reg [2:0] ph = 3'h0;
  // strobe four cycles high, four low, only while running
  always @(posedge clk)
  begin
    density_status_line <= nrzi_mode;
    ph <= run ? ph + 3'h1 : 3'h0;
    write_data_strobe <= run & ph[2];
  end
endmodule

//--- bench/tape_option_chk.sv
// port assertions for tape_option_control
`timescale 1ns/1ps
module tape_option_chk (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire address_width_switch,
  input wire remote_density_switch,
  input wire streaming_mode_switch,
  input wire density_status_override_switch,
  input wire extended_gap_switch,
  input wire fly_command_inhibit_switch,
  input wire strobe_edge_switch,
  input wire local_density_select,
  input wire density_status_line,
  input wire [21:0] dma_addr,
  input wire [21:0] bus_addr_r,
  input wire fly_command_req,
  input wire fly_command_issue_r,
  input wire write_data_strobe,
  input wire write_char_taken_r,
  input wire window_missed_r,
  input wire high_density_r,
  input wire expect_check_chars_r,
  input wire [3:0] gap_length_r
);
  reg [6:0] s;
  // switches as the design holds them after reset
  always @(posedge clk)
    if (rst)
      s <= {strobe_edge_switch, fly_command_inhibit_switch, extended_gap_switch, density_status_override_switch,
        streaming_mode_switch, remote_density_switch, address_width_switch};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_apb_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held");
  a_addr_width: assert property (!$past(rst) |-> bus_addr_r == (s[0] ? $past(dma_addr) : {4'h0, $past(dma_addr[17:0])}))
    else $error("bus address width");
  a_local_density: assert property (!$past(rst) && !s[1] |-> high_density_r == $past(local_density_select))
    else $error("local density");
  a_check_chars: assert property (!$past(rst) |-> expect_check_chars_r == (!s[3] && $past(density_status_line)))
    else $error("check characters");
  a_gap_len: assert property (!$past(rst) |-> gap_length_r == ((!s[2] && s[4]) ? 4'hc : 4'h6))
    else $error("gap length");
  a_fly_inhibit: assert property (!$past(rst) |-> fly_command_issue_r == (!s[5] && $past(fly_command_req)))
    else $error("fly command");
  a_strobe_edge: assert property ($rose(write_char_taken_r) |-> write_data_strobe == s[6])
    else $error("strobe edge");
  a_miss_stream: assert property (window_missed_r |-> !s[2] ##1 !window_missed_r)
    else $error("window miss");
  cover property (window_missed_r);
  cover property ($rose(write_char_taken_r));
  cover property (pready && pslverr);
endmodule

bind tape_option_control tape_option_chk tape_option_chk_i (
  .clk(clk),
  .rst(rst),
  .psel(psel),
  .penable(penable),
  .pready(pready),
  .pslverr(pslverr),
  .address_width_switch(address_width_switch),
  .remote_density_switch(remote_density_switch),
  .streaming_mode_switch(streaming_mode_switch),
  .density_status_override_switch(density_status_override_switch),
  .extended_gap_switch(extended_gap_switch),
  .fly_command_inhibit_switch(fly_command_inhibit_switch),
  .strobe_edge_switch(strobe_edge_switch),
  .local_density_select(local_density_select),
  .density_status_line(density_status_line),
  .dma_addr(dma_addr),
  .bus_addr_r(bus_addr_r),
  .fly_command_req(fly_command_req),
  .fly_command_issue_r(fly_command_issue_r),
  .write_data_strobe(write_data_strobe),
  .write_char_taken_r(write_char_taken_r),
  .window_missed_r(window_missed_r),
  .high_density_r(high_density_r),
  .expect_check_chars_r(expect_check_chars_r),
  .gap_length_r(gap_length_r)
);

//--- bench/tape_option_control_tb.sv
// self-checking bench for tape_option_control
`timescale 1ns/1ps
module tape_option_control_tb;
  reg clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, lds = 0, nrzi = 0, run = 0, rdone = 0, rwc = 0, fly = 0, e;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0000_0000, rd, x = 32'h0000_5343;
  reg [21:0] dma = 22'h00_0000;
  reg [7:0] nch = 8'h00;
  reg [6:0] sw = 7'h00;
  wire [31:0] prdata;
  wire [21:0] bus_addr_r;
  wire [7:0] write_data_r;
  wire [3:0] gap_length_r;
  wire pready, pslverr, density_status_line, write_data_strobe, window_missed_r, fly_command_issue_r;
  wire write_char_taken_r, high_density_r, expect_check_chars_r;
  integer error_cnt = 0, tests_run = 0, i, k, n;
  tape_option_control #(.NORMAL_WINDOW_CYCLES(20), .EXTENDED_WINDOW_CYCLES(50)) tape_option_control_i (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .density_status_line(density_status_line),
    .write_data_strobe(write_data_strobe), .bus_addr_r(bus_addr_r), .window_missed_r(window_missed_r),
    .fly_command_issue_r(fly_command_issue_r), .write_data_r(write_data_r), .write_char_taken_r(write_char_taken_r),
    .high_density_r(high_density_r), .expect_check_chars_r(expect_check_chars_r), .gap_length_r(gap_length_r),
    .address_width_switch(sw[0]), .remote_density_switch(sw[1]), .streaming_mode_switch(sw[2]),
    .density_status_override_switch(sw[3]), .extended_gap_switch(sw[4]), .fly_command_inhibit_switch(sw[5]),
    .strobe_edge_switch(sw[6]), .local_density_select(lds), .dma_addr(dma), .record_done(rdone),
    .rw_command(rwc), .fly_command_req(fly), .next_write_char(nch));
  transport_model transport_model_i (.clk(clk), .nrzi_mode(nrzi), .run(run),
    .density_status_line(density_status_line), .write_data_strobe(write_data_strobe));
  // clock and watchdog
  always #20 clk = ~clk;
  initial
  begin
    #200000;
    error_cnt = error_cnt + 1;
    test_done;
  end
  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  function integer exp_wait(input [6:0] s, input integer stopped);
    exp_wait = stopped ? 80 : (s[4] ? 52 : 22);
  endfunction
  // status word: b6 wide address, b5 missed, b4 running, b3 fly on, b2 ext gap, b1 check chars, b0 density
  function [31:0] exp_status(input [6:0] s, input [7:0] cm, input l, input nz, input m);
    exp_status = {25'h000_0000, s[0], m, 1'b0, ~s[5], ~s[2] & s[4], ~s[3] & nz, s[1] ? cm[0] : l};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task apb(input [11:0] a, input w, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask
  task test_done;
    begin
      $display("checks=%0d errors=%0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // factory, all on, then random switch sets
  initial
  begin
    for (i = 0; i < 8; i = i + 1)
    begin
      x = xs(x);
      @(posedge clk);
      sw <= (i == 0) ? 7'h00 : (i == 1) ? 7'h7f : x[6:0];
      rst <= 1;
      repeat (3) @(posedge clk);
      // with override on, a high line flags a gcr transport, never nrzi
      rst <= 0; nrzi <= x[8]; lds <= x[9]; fly <= x[11]; dma <= x[31:10];
      apb(12'h004, 1, {24'h00_0000, x[7:0]});
      apb(12'h004, 0, 0);
      chk(rd, {24'h00_0000, x[7:0]});
      apb(12'h000, 0, 0);
      chk(rd, {25'h000_0000, sw});
      sw <= ~sw;
      apb(12'h000, 0, 0);
      chk(rd, {25'h000_0000, ~sw});
      sw <= ~sw;
      apb(12'h010, 0, 0);
      chk(e, 1);
      chk(rd, 0);
      @(negedge clk);
      chk(bus_addr_r, sw[0] ? dma : {4'h0, dma[17:0]});
      chk(high_density_r, sw[1] ? x[0] : lds);
      chk(expect_check_chars_r, ~sw[3] & nrzi);
      chk(gap_length_r, (!sw[2] && sw[4]) ? 4'hc : 4'h6);
      chk(fly_command_issue_r, ~sw[5] & fly);
      for (k = 0; k < 2 && !sw[2]; k = k + 1)
      begin
        @(posedge clk);
        rdone <= 1; rwc <= 0;
        @(posedge clk);
        rdone <= 0; rwc <= k[0];
        n = 0;
        while (window_missed_r !== 1'b1 && n < 80)
        begin
          @(negedge clk);
          n = n + 1;
        end
        chk(n, exp_wait(sw, k));
      end
      // sticky missed flag, then write one to clear it
      apb(12'h008, 0, 0);
      chk(rd, exp_status(sw, x[7:0], lds, nrzi, !sw[2]));
      apb(12'h008, 1, 32'h0000_0020);
      apb(12'h008, 0, 0);
      chk(rd, exp_status(sw, x[7:0], lds, nrzi, 1'b0));
      @(posedge clk);
      rwc <= 0; nch <= x[7:0] ^ 8'h5a; run <= 1;
      n = 0;
      while (write_char_taken_r !== 1'b1 && n < 40)
      begin
        @(negedge clk);
        n = n + 1;
      end
      chk(write_char_taken_r, 1);
      chk(write_data_r, x[7:0] ^ 8'h5a);
      chk(write_data_strobe, sw[6]);
      @(posedge clk);
      run <= 0;
    end
    test_done;
  end
endmodule
